/* src/delay_timer_pkg.sv */
// types shared by the delay timer
package delay_timer_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_DELAY = 3'b001,
		ST_PULSE = 3'b010,
		ST_DONE = 3'b011,
		ST_SECOND = 3'b100
	} phase_e;
endpackage

/* src/delay_timer_regs.svh */
// constants and function select codes for the multi-mode delay timer
`ifndef DELAY_TIMER_REGS_SVH
`define DELAY_TIMER_REGS_SVH
`define FUNC_ONESHOT 3'h0
`define FUNC_SEQUENCE 3'h1
`define FUNC_CYCLE 3'h2
`define FUNC_OFFDELAY 3'h3
`define FUNC_RECYCLE 3'h4
`define CNT_ZERO 32'h0
`define CNT_ONE 32'h1
`endif

/* src/multi_mode_delay_timer.sv */
// multi-function delay timer core
`timescale 1ns/10ps
`default_nettype none
`include "delay_timer_regs.svh"
module multi_mode_delay_timer
	import delay_timer_pkg::*;
#(
	parameter int CW = 24,
	parameter int PW = 16
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [2:0] funcSel,
	input wire logic [PW-1:0] prescale,
	input wire logic [CW-1:0] firstInterval,
	input wire logic [CW-1:0] secondInterval,
	input wire logic [CW-1:0] pulseWidth,
	input wire logic powerPresent,
	input wire logic startIn,
	input wire logic resetIn,
	output logic outOne,
	output logic outTwo
);
	typedef struct packed {
		phase_e phase;
		logic [CW-1:0] count;
		logic powerSeen;
		logic outOne;
		logic outTwo;
	} state_s;
	state_s st_reg;
	state_s st_next;
	logic tick;

	function automatic logic [CW-1:0] offGap(input logic [CW-1:0] full, input logic [CW-1:0] pw);
		offGap = (full > pw) ? full - pw : CW'(`CNT_ZERO);
	endfunction

	tick_divider #(.W(PW)) u_div (
		.clk(clk),
		.arst_n(arst_n),
		.divide(prescale),
		.tick(tick)
	);

	logic expired;
	assign expired = tick && (st_reg.count <= CW'(`CNT_ONE));

	always_comb begin
		st_next = st_reg;
		st_next.powerSeen = powerPresent;
		if (tick && st_reg.count != CW'(`CNT_ZERO)) begin
			st_next.count = st_reg.count - CW'(`CNT_ONE);
		end
		case (funcSel)
			`FUNC_ONESHOT: begin
				st_next.outTwo = 1'b0;
				if (!powerPresent || resetIn || !startIn) begin
					st_next.phase = ST_IDLE;
					st_next.outOne = 1'b0;
					st_next.count = CW'(`CNT_ZERO);
				end else begin
					case (st_reg.phase)
						ST_IDLE: begin
							st_next.phase = ST_DELAY;
							st_next.count = firstInterval;
						end
						ST_DELAY: begin
							if (expired) begin
								st_next.phase = ST_PULSE;
								st_next.outOne = 1'b1;
								st_next.count = pulseWidth;
							end
						end
						ST_PULSE: begin
							if (expired) begin
								st_next.phase = ST_DONE;
								st_next.outOne = 1'b0;
							end
						end
						default: st_next.phase = ST_DONE;
					endcase
				end
			end
			`FUNC_SEQUENCE, `FUNC_RECYCLE: begin
				if (!powerPresent) begin
					st_next.phase = ST_IDLE;
					st_next.outOne = 1'b0;
					st_next.outTwo = 1'b0;
					st_next.count = CW'(`CNT_ZERO);
				end else begin
					case (st_reg.phase)
						ST_IDLE: begin
							st_next.phase = ST_DELAY;
							st_next.count = firstInterval;
							st_next.outOne = 1'b0;
							st_next.outTwo = 1'b0;
						end
						ST_DELAY: begin
							if (expired) begin
								st_next.phase = ST_SECOND;
								st_next.count = secondInterval;
								st_next.outOne = 1'b1;
								st_next.outTwo = (funcSel == `FUNC_RECYCLE);
							end
						end
						ST_SECOND: begin
							if (expired) begin
								if (funcSel == `FUNC_RECYCLE) begin
									st_next.phase = ST_DELAY;
									st_next.count = firstInterval;
									st_next.outOne = 1'b0;
									st_next.outTwo = 1'b0;
								end else begin
									st_next.phase = ST_DONE;
									st_next.outTwo = 1'b1;
								end
							end
						end
						default: st_next.phase = st_reg.phase;
					endcase
				end
			end
			`FUNC_CYCLE: begin
				st_next.outTwo = 1'b0;
				// only reset or power loss stops
				if (!powerPresent || resetIn) begin
					st_next.phase = ST_IDLE;
					st_next.outOne = 1'b0;
					st_next.count = CW'(`CNT_ZERO);
				end else begin
					case (st_reg.phase)
						ST_IDLE: begin
							if (startIn) begin
								st_next.phase = ST_DELAY;
								st_next.count = firstInterval;
							end
						end
						ST_DELAY: begin
							if (expired) begin
								st_next.phase = ST_PULSE;
								st_next.outOne = 1'b1;
								st_next.count = pulseWidth;
							end
						end
						ST_PULSE: begin
							if (expired) begin
								st_next.phase = ST_DELAY;
								st_next.outOne = 1'b0;
								st_next.count = offGap(firstInterval, pulseWidth);
							end
						end
						default: st_next.phase = ST_IDLE;
					endcase
				end
			end
			`FUNC_OFFDELAY: begin
				st_next.outTwo = 1'b0;
				if (powerPresent) begin
					st_next.phase = ST_IDLE;
					st_next.outOne = 1'b1;
					st_next.count = firstInterval;
				end else if (st_reg.powerSeen) begin
					st_next.phase = ST_DELAY;
					st_next.count = firstInterval;
				end else if (st_reg.phase == ST_DELAY && expired) begin
					st_next.phase = ST_DONE;
					st_next.outOne = 1'b0;
				end
			end
			default: begin
				st_next.phase = ST_IDLE;
				st_next.outOne = 1'b0;
				st_next.outTwo = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign outOne = st_reg.outOne;
	assign outTwo = st_reg.outTwo;

	property p_oneshot_abort;
		@(posedge clk) disable iff (!arst_n)
		(funcSel == `FUNC_ONESHOT && !startIn) |=> !outOne;
	endproperty
	a_oneshot_abort: assert property (p_oneshot_abort) else $error("one-shot not cleared");
	property p_power_loss;
		@(posedge clk) disable iff (!arst_n)
		(funcSel == `FUNC_RECYCLE && !powerPresent) |=> (!outOne && !outTwo);
	endproperty
	a_power_loss: assert property (p_power_loss) else $error("recycler not cleared");
	property p_offdelay_on;
		@(posedge clk) disable iff (!arst_n)
		(funcSel == `FUNC_OFFDELAY && powerPresent) |=> outOne;
	endproperty
	a_offdelay_on: assert property (p_offdelay_on) else $error("off-delay output off");
	property p_seq_order;
		@(posedge clk) disable iff (!arst_n)
		(funcSel == `FUNC_SEQUENCE && outTwo) |-> outOne;
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("output two before one");
	property p_seq_hold;
		@(posedge clk) disable iff (!arst_n)
		(funcSel == `FUNC_SEQUENCE && outTwo && powerPresent) |=> outTwo;
	endproperty
	a_seq_hold: assert property (p_seq_hold) else $error("sequence output dropped");
	property p_cycle_reset;
		@(posedge clk) disable iff (!arst_n)
		(funcSel == `FUNC_CYCLE && resetIn) |=> (!outOne && st_reg.phase == ST_IDLE);
	endproperty
	a_cycle_reset: assert property (p_cycle_reset) else $error("cycle not stopped");
	property p_oneshot_done;
		@(posedge clk) disable iff (!arst_n)
		(funcSel == `FUNC_ONESHOT && st_reg.phase == ST_DONE) |-> !outOne;
	endproperty
	a_oneshot_done: assert property (p_oneshot_done) else $error("one-shot on after pulse");
	property p_recycle_pair;
		@(posedge clk) disable iff (!arst_n)
		(funcSel == `FUNC_RECYCLE) |-> (outOne == outTwo);
	endproperty
	a_recycle_pair: assert property (p_recycle_pair) else $error("recycler outputs differ");
endmodule
`default_nettype wire

/* src/tick_divider.sv */
// prescaler producing a one-cycle tick enable
`timescale 1ns/10ps
`default_nettype none
`include "delay_timer_regs.svh"
module tick_divider #(
	parameter int W = 16
) (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [W-1:0] divide,
	output logic tick
);
	typedef struct packed {
		logic [W-1:0] count;
		logic tick;
	} div_s;
	div_s st_reg;
	div_s st_next;
	always_comb begin
		st_next = st_reg;
		st_next.tick = 1'b0;
		if (st_reg.count >= divide) begin
			st_next.count = '0;
			st_next.tick = 1'b1;
		end else begin
			st_next.count = st_reg.count + W'(`CNT_ONE);
		end
	end
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
	assign tick = st_reg.tick;
endmodule
`default_nettype wire

/* verification/ctrl_partner.sv */
// control side model driving power, start and reset
`timescale 1ns/10ps
`default_nettype none
module ctrl_partner (
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [2:0] want,
	output logic powerPresent,
	output logic startIn,
	output logic resetIn
);
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) {powerPresent, startIn, resetIn} <= 3'h0;
		else {powerPresent, startIn, resetIn} <= want;
	end
endmodule
`default_nettype wire

/* verification/multi_mode_delay_timer_tb_top.sv */
// bench for the multi-mode delay timer
`timescale 1ns/10ps
`default_nettype none
module multi_mode_delay_timer_tb_top;
	localparam int F = 10;
	localparam int S = 5;
	localparam int P = 4;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic [2:0] funcSel = 3'h0;
	logic [2:0] want = 3'h0;
	logic [15:0] prescale = 16'h0000;
	logic powerPresent, startIn, resetIn, outOne, outTwo;
	int miscompares = 0;
	int n_compared = 0;
	int n;
	initial begin
		forever #4 clk = ~clk;
	end
	ctrl_partner ctl (.clk(clk), .arst_n(arst_n), .want(want), .powerPresent(powerPresent),
		.startIn(startIn), .resetIn(resetIn));
	multi_mode_delay_timer uut (.clk(clk), .arst_n(arst_n), .funcSel(funcSel),
		.prescale(prescale), .firstInterval(24'(F)), .secondInterval(24'(S)),
		.pulseWidth(24'(P)), .powerPresent(powerPresent), .startIn(startIn),
		.resetIn(resetIn), .outOne(outOne), .outTwo(outTwo));
	task automatic check(input string what, input logic seen, input logic exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %b seen %b", what, exp, seen);
		end
	endtask
	task automatic step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic drive(input logic [2:0] w, input int c);
		want = w;
		step(c);
	endtask
	task automatic waitOut(input logic sel, input logic v, input int len);
		n = 0;
		while ((sel ? outTwo : outOne) !== v && n < 200) begin
			step(1);
			n++;
		end
		check("interval", n >= len - 1 && n <= len + 3, 1'b1);
	endtask
	task automatic restart(input logic [2:0] f);
		arst_n = 1'b0;
		funcSel = f;
		want = 3'h0;
		step(2);
		arst_n = 1'b1;
		step(1);
	endtask
	task automatic one_shot();
		restart(3'h0);
		drive(3'b110, 0);
		waitOut(1'b0, 1'b1, F);
		waitOut(1'b0, 1'b0, P);
		step(2 * F);
		check("held off", outOne, 1'b0);
		drive(3'b100, 2);
		drive(3'b110, 0);
		waitOut(1'b0, 1'b1, F);
		drive(3'b111, 3);
		check("reset clears", outOne, 1'b0);
	endtask
	task automatic sequence_start();
		restart(3'h1);
		drive(3'b100, 0);
		waitOut(1'b0, 1'b1, F);
		check("two off", outTwo, 1'b0);
		waitOut(1'b1, 1'b1, S);
		step(3 * F);
		check("one held", outOne, 1'b1);
		check("two held", outTwo, 1'b1);
		drive(3'b000, 3);
		check("one down", outOne | outTwo, 1'b0);
	endtask
	task automatic cycling();
		restart(3'h2);
		drive(3'b110, 1);
		drive(3'b100, 0);
		waitOut(1'b0, 1'b1, F);
		check("two idle", outTwo, 1'b0);
		waitOut(1'b0, 1'b0, P);
		waitOut(1'b0, 1'b1, F - P);
		waitOut(1'b0, 1'b0, P);
		waitOut(1'b0, 1'b1, F - P);
		drive(3'b101, 3);
		check("stop", outOne, 1'b0);
		drive(3'b100, 2 * F);
		check("stays stopped", outOne, 1'b0);
	endtask
	task automatic off_delay();
		restart(3'h3);
		drive(3'b100, 3);
		check("on at power", outOne, 1'b1);
		drive(3'b000, F / 2);
		check("on during delay", outOne, 1'b1);
		drive(3'b100, F);
		check("kept on", outOne, 1'b1);
		drive(3'b000, 0);
		waitOut(1'b0, 1'b0, F);
	endtask
	task automatic recycler();
		restart(3'h4);
		drive(3'b100, 0);
		waitOut(1'b0, 1'b1, F);
		check("both on", outTwo, 1'b1);
		waitOut(1'b0, 1'b0, S);
		check("both off", outTwo, 1'b0);
		waitOut(1'b0, 1'b1, F);
		drive(3'b000, 3);
		check("forced off", outOne | outTwo, 1'b0);
	endtask
	task automatic prescaled();
		prescale = 16'h0001;
		restart(3'h0);
		drive(3'b110, 0);
		waitOut(1'b0, 1'b1, 2 * F);
		waitOut(1'b0, 1'b0, 2 * P);
		prescale = 16'h0000;
	endtask
	task automatic unused_code();
		restart(3'h5);
		drive(3'b110, F);
		check("unused code idle", outOne | outTwo, 1'b0);
	endtask
	task automatic complete_run();
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		#100us;
		miscompares++;
		complete_run();
	end
	initial begin
		one_shot();
		sequence_start();
		cycling();
		off_delay();
		recycler();
		prescaled();
		unused_code();
		complete_run();
	end
endmodule
`default_nettype wire
